// ---- inc/prot_region_defs.svh ----
// constants for the protection region base and attribute block
// ****************************************************************
// How it works
// - base write with valid flag set loads region number, base goes to that region
// - base write with valid clear keeps region number, updates selected region
// - valid flag at bit 4 always reads back as zero
// - region field bits 3:0 of base register read the current region number
// - base address sits at bits 31:N, bits N-1:5 are reserved
// - with a 32-byte region the base spans bits 31:5
// - a 4GB region has no base field and covers everything from zero
// - attribute/size register is a whole word: attributes high, size and enables low
// - execute-never at bit 28 blocks instruction fetches from the region
// - access permission is three bits at 26:24
// - type extension 21:19, shareable 18, cacheable 17, bufferable 16
// - in regions of 256 bytes or more, each of eight subregion disable bits 15:8 disables its subregion
// - size field at bits 5:1, smallest value allowed is 4
// - bit 0 enables the region, protection applies only when set
// - region size in bytes is two to the power size plus one
// - sixteen regions, region number ranges over 0 to 15
// ****************************************************************
`ifndef PROT_REGION_DEFS_SVH
`define PROT_REGION_DEFS_SVH

// ****************************************************************
// register map, byte addresses
// ****************************************************************
`define OFS_REGION_NUMBER     8'h00
`define OFS_REGION_BASE       8'h04
`define OFS_REGION_ATTR_SIZE  8'h08

// ****************************************************************
// fields
// ****************************************************************
`define NUM_REGIONS           16
`define BASE_VALID_BIT        4
`define BASE_LSB              5
`define ATTR_EN_BIT           0
`define ATTR_SIZE_LSB         1
`define ATTR_SUBREG_OFF_LSB   8
`define ATTR_B_BIT            16
`define ATTR_C_BIT            17
`define ATTR_S_BIT            18
`define ATTR_TYPE_EXT_LSB     19
`define ATTR_PERMISSION_LSB   24
`define ATTR_EXEC_NEVER_BIT   28
`define ATTR_WR_MASK          32'h173FFF3F
`define SIZE_MIN              5'h04
`define SIZE_SUBREGION_MIN    5'h07
`define HSIZE_WORD            3'h2

// ****************************************************************
// reset values
// ****************************************************************
`define RST_REGION_NUMBER     4'h0
`define RST_BASE              27'h0000000
`define RST_ATTR              32'h00000000

`endif

// ---- inc/prot_region_pkg.sv ----
// types and helpers shared by the protection region files
package prot_region_pkg;

  typedef logic [3:0]  region_idx_type;
  typedef logic [26:0] base_type;
  typedef logic [31:0] word_type;
  typedef logic [1:0]  htrans_type;

  typedef enum logic {ST_IDLE, ST_READ} bus_state_type;

  // keep mask over address bits 31:5 for a given size field; bit k is address bit k+5
  function automatic base_type base_keep(input logic [4:0] size);
    logic [5:0] n;
    base_type   m;
    n = (size < 5'h04) ? 6'd5 : ({1'b0, size} + 6'd1);
    for (int k = 0; k < 27; k++) begin
      m[k] = ((k + 5) >= int'(n));
    end
    return m;
  endfunction

endpackage

// ---- design/region_entry.sv ----
// storage of base and attributes for one region
`timescale 1ns/1ps
`include "prot_region_defs.svh"
module region_entry (
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_wr_base,
  input  wire logic                      i_wr_attr,
  input  wire prot_region_pkg::word_type i_wdata,
  output prot_region_pkg::base_type      o_base,
  output prot_region_pkg::word_type      o_attr
);
  import prot_region_pkg::*;

  base_type base_r;
  word_type attr_r;
  word_type attr_nxt;

  // ****************************************************************
  // storage
  // ****************************************************************
  // raw base kept; reserved low bits are masked where read or compared
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      base_r <= `RST_BASE;
    end else if (i_wr_base) begin
      base_r <= i_wdata[31:`BASE_LSB];
    end
  end

  always_comb begin
    attr_nxt = i_wdata & `ATTR_WR_MASK;
    // undersized values clamp to the minimum so the compare never goes below 32 bytes
    if (i_wdata[5:1] < `SIZE_MIN) begin
      attr_nxt[5:1] = `SIZE_MIN;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      attr_r <= `RST_ATTR;
    end else if (i_wr_attr) begin
      attr_r <= attr_nxt;
    end
  end

  assign o_base = base_r;
  assign o_attr = attr_r;
endmodule

// ---- design/region_match.sv ----
// address compare of one region against a checked address
`timescale 1ns/1ps
`include "prot_region_defs.svh"
module region_match (
  input  wire prot_region_pkg::base_type i_base,
  input  wire prot_region_pkg::word_type i_attr,
  input  wire prot_region_pkg::word_type i_addr,
  output logic                           o_hit
);
  import prot_region_pkg::*;

  logic [4:0] size;
  logic [5:0] sub_shift;
  logic [2:0] sub_idx;
  logic       sub_off;
  base_type   mism;

  assign size      = i_attr[5:1];
  // subregion index is the top three bits below N
  assign sub_shift = {1'b0, size} - 6'd2;
  assign sub_idx   = 3'(i_addr >> sub_shift);
  // no subregions at 128 bytes or below, so the disable bits are not looked at
  assign sub_off   = (size >= `SIZE_SUBREGION_MIN) &&
                     i_attr[`ATTR_SUBREG_OFF_LSB + sub_idx];
  assign mism      = (i_addr[31:`BASE_LSB] ^ i_base) & base_keep(size);
  assign o_hit     = i_attr[`ATTR_EN_BIT] && (mism == '0) && !sub_off;
endmodule

// ---- design/protection_region_base_attr.sv ----
// top: region number, base and attribute registers on AHB-Lite, plus address check
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "prot_region_defs.svh"
module protection_region_base_attr (
  input  wire logic                        I_CLK_SYS,
  input  wire logic                        I_ARST_N,
  input  wire logic                        I_HSEL,
  input  wire logic [31:0]                 I_HADDR,
  input  wire prot_region_pkg::htrans_type I_HTRANS,
  input  wire logic                        I_HWRITE,
  input  wire logic [2:0]                  I_HSIZE,
  input  wire logic [31:0]                 I_HWDATA,
  input  wire logic                        I_HREADY,
  output logic                             O_HREADYOUT,
  output logic [31:0]                      O_HRDATA,
  output logic                             O_HRESP,
  input  wire logic                        I_CHK_VALID,
  input  wire logic [31:0]                 I_CHK_ADDR,
  input  wire logic                        I_CHK_FETCH,
  output logic                             O_CHK_DONE,
  output logic                             O_CHK_HIT,
  output logic [3:0]                       O_CHK_REGION,
  output logic [2:0]                       O_CHK_PERMISSION,
  output logic                             O_CHK_FETCH_BLOCK
);
  import prot_region_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  bus_state_type  state_r;
  logic           hreadyout_r;
  logic [31:0]    hrdata_r;
  logic           hresp_r;
  logic [7:0]     addr_r;
  logic           wr_pend_r;
  logic           accept;
  logic           rd_start;
  logic           wr_start;
  logic           wr_number;
  logic           wr_base;
  logic           wr_attr;
  region_idx_type region_r;
  region_idx_type base_target;
  word_type       rd_value;
  base_type       sel_base;
  word_type       sel_attr;
  logic [4:0]     sel_size;

  base_type                 base_arr [`NUM_REGIONS];
  word_type                 attr_arr [`NUM_REGIONS];
  logic [`NUM_REGIONS-1:0]  hit_vec;
  logic [`NUM_REGIONS-1:0]  wr_base_vec;
  logic [`NUM_REGIONS-1:0]  wr_attr_vec;

  logic           chk_hit;
  region_idx_type chk_region;
  word_type       chk_attr;
  logic [2:0]     chk_perm;
  logic           chk_no_exec;
  logic           chk_done_r;
  logic           chk_hit_r;
  region_idx_type chk_region_r;
  logic [2:0]     chk_perm_r;
  logic           chk_block_r;

  // ****************************************************************
  // bus slave
  // ****************************************************************
  assign accept   = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign rd_start = accept && !I_HWRITE && (state_r == ST_IDLE);
  assign wr_start = accept && I_HWRITE && (state_r == ST_IDLE);

  // ****************************************************************
  // bus state
  // ****************************************************************
  // reads take one wait state so a write just before them is already in the registers
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (rd_start) begin
            state_r <= ST_READ;
          end
        end
        ST_READ: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ready is low only in the first data-phase cycle of a read
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hreadyout_r <= 1'b1;
    end else if (state_r == ST_READ) begin
      hreadyout_r <= 1'b1;
    end else if (rd_start) begin
      hreadyout_r <= 1'b0;
    end
  end

  // read data is loaded at the end of a read's wait cycle and stands until the end of the wait cycle of the next read
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hrdata_r <= 32'h00000000;
    end else if (state_r == ST_READ) begin
      hrdata_r <= rd_value;
    end
  end

  // ****************************************************************
  // data phase
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    // the offset is kept for the data phase, where the write lands or the read is decoded
    if (!I_ARST_N) begin
      addr_r <= 8'h00;
    end else if (rd_start || wr_start) begin
      addr_r <= I_HADDR[7:0];
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      wr_pend_r <= 1'b0;
    end else if (wr_start) begin
      // partial-word writes are dropped; the registers take whole words only
      wr_pend_r <= (I_HSIZE == `HSIZE_WORD);
    end else begin
      wr_pend_r <= 1'b0;
    end
  end

  // every answer is OKAY
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
    end
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  assign wr_number = wr_pend_r && (addr_r == `OFS_REGION_NUMBER);
  assign wr_base   = wr_pend_r && (addr_r == `OFS_REGION_BASE);
  assign wr_attr   = wr_pend_r && (addr_r == `OFS_REGION_ATTR_SIZE);

  // ****************************************************************
  // region number
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      region_r <= `RST_REGION_NUMBER;
    end else if (wr_number) begin
      // only sixteen regions exist, so the upper bits of the field are not kept
      region_r <= I_HWDATA[3:0];
    end else if (wr_base && I_HWDATA[`BASE_VALID_BIT]) begin
      region_r <= I_HWDATA[3:0];
    end
  end

  // valid clear: written region field ignored, selected region used
  assign base_target = I_HWDATA[`BASE_VALID_BIT] ? I_HWDATA[3:0] : region_r;

  // ****************************************************************
  // region storage and compare
  // ****************************************************************
  for (genvar g = 0; g < `NUM_REGIONS; g++) begin : g_region
    assign wr_base_vec[g] = wr_base && (base_target == 4'(g));
    assign wr_attr_vec[g] = wr_attr && (region_r == 4'(g));

    region_entry u_entry (
      .i_clk     (I_CLK_SYS),
      .i_arst_n  (I_ARST_N),
      .i_wr_base (wr_base_vec[g]),
      .i_wr_attr (wr_attr_vec[g]),
      .i_wdata   (I_HWDATA),
      .o_base    (base_arr[g]),
      .o_attr    (attr_arr[g])
    );

    region_match u_match (
      .i_base (base_arr[g]),
      .i_attr (attr_arr[g]),
      .i_addr (I_CHK_ADDR),
      .o_hit  (hit_vec[g])
    );
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  // the selected region feeds every read of base and attributes
  assign sel_base = base_arr[region_r];
  assign sel_attr = attr_arr[region_r];
  assign sel_size = sel_attr[`ATTR_SIZE_LSB +: 5];

  always_comb begin
    rd_value = 32'h00000000;
    unique case (addr_r)
      `OFS_REGION_NUMBER: begin
        rd_value = {28'h0000000, region_r};
      end
      `OFS_REGION_BASE: begin
        // valid flag and reserved bits below N always read zero
        rd_value = {sel_base & base_keep(sel_size), 1'b0, region_r};
      end
      `OFS_REGION_ATTR_SIZE: begin
        rd_value = sel_attr;
      end
      default: begin
        rd_value = 32'h00000000;
      end
    endcase
  end

  // ****************************************************************
  // address check
  // ****************************************************************
  // the highest numbered enabled region that matches takes priority
  always_comb begin
    chk_hit    = 1'b0;
    chk_region = 4'h0;
    for (int k = 0; k < `NUM_REGIONS; k++) begin
      if (hit_vec[k]) begin
        chk_hit    = 1'b1;
        chk_region = 4'(k);
      end
    end
  end

  // done is a plain one-cycle echo of the request
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      chk_done_r <= 1'b0;
    end else begin
      chk_done_r <= I_CHK_VALID;
    end
  end

  // ****************************************************************
  // matched region fields
  // ****************************************************************
  assign chk_attr    = attr_arr[chk_region];
  assign chk_perm    = chk_hit ? chk_attr[`ATTR_PERMISSION_LSB +: 3] : 3'h0;
  // data accesses are never blocked; only fetches look at the execute-never bit
  assign chk_no_exec = chk_hit && I_CHK_FETCH && chk_attr[`ATTR_EXEC_NEVER_BIT];

  // ****************************************************************
  // check results
  // ****************************************************************
  // results stand until the next check so a slow consumer can still read them
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      chk_hit_r <= 1'b0;
    end else if (I_CHK_VALID) begin
      chk_hit_r <= chk_hit;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      chk_region_r <= 4'h0;
    end else if (I_CHK_VALID) begin
      chk_region_r <= chk_region;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      chk_perm_r <= 3'h0;
    end else if (I_CHK_VALID) begin
      chk_perm_r <= chk_perm;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      chk_block_r <= 1'b0;
    end else if (I_CHK_VALID) begin
      chk_block_r <= chk_no_exec;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign O_HREADYOUT       = hreadyout_r;
  assign O_HRDATA          = hrdata_r;
  assign O_HRESP           = hresp_r;
  assign O_CHK_DONE        = chk_done_r;
  assign O_CHK_HIT         = chk_hit_r;
  assign O_CHK_REGION      = chk_region_r;
  assign O_CHK_PERMISSION  = chk_perm_r;
  assign O_CHK_FETCH_BLOCK = chk_block_r;
endmodule

// ---- tb/prot_region_chk.sv ----
// port assertions for the protection region block
`timescale 1ns/1ps
module prot_region_chk (
  input wire logic                        I_CLK_SYS,
  input wire logic                        I_ARST_N,
  input wire logic                        I_HSEL,
  input wire prot_region_pkg::htrans_type I_HTRANS,
  input wire logic                        I_HWRITE,
  input wire logic                        I_HREADY,
  input wire logic                        O_HREADYOUT,
  input wire logic [31:0]                 O_HRDATA,
  input wire logic                        O_HRESP,
  input wire logic                        I_CHK_VALID,
  input wire logic                        I_CHK_FETCH,
  input wire logic                        O_CHK_DONE,
  input wire logic                        O_CHK_HIT,
  input wire logic [3:0]                  O_CHK_REGION,
  input wire logic [2:0]                  O_CHK_PERMISSION,
  input wire logic                        O_CHK_FETCH_BLOCK
);
  import prot_region_pkg::*;
  // ****************************************
  // bus and check port timing
  // ****************************************
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);
  sequence take_s;
    I_HSEL && I_HTRANS[1] && I_HREADY && O_HREADYOUT;
  endsequence
  sequence wait_s;
    !O_HREADYOUT ##1 O_HREADYOUT;
  endsequence
  rd_wait_a: assert property (take_s ##0 !I_HWRITE |=> wait_s)
    else $error("read wait cycle wrong");
  wr_nowait_a: assert property (take_s ##0 I_HWRITE |=> O_HREADYOUT)
    else $error("write stalled");
  // read data must not move outside a wait cycle, or a master could take stale data
  rdata_hold_a: assert property (O_HREADYOUT |=> $stable(O_HRDATA))
    else $error("read data moved");
  resp_okay_a: assert property (O_HRESP == 1'b0)
    else $error("response not okay");
  chk_done_a: assert property (I_CHK_VALID |=> O_CHK_DONE)
    else $error("check not done");
  chk_hold_a: assert property (!I_CHK_VALID |=> !O_CHK_DONE && $stable(O_CHK_HIT))
    else $error("check result moved");
  miss_zero_a: assert property (O_CHK_DONE && !O_CHK_HIT |->
    O_CHK_REGION == 4'h0 && O_CHK_PERMISSION == 3'h0 && !O_CHK_FETCH_BLOCK)
    else $error("miss not zero");
  data_noblk_a: assert property (I_CHK_VALID && !I_CHK_FETCH |=> !O_CHK_FETCH_BLOCK)
    else $error("data access blocked");
  blk_hit_a: assert property (O_CHK_FETCH_BLOCK |-> O_CHK_HIT)
    else $error("block without hit");
endmodule

// ---- tb/test_protection_region_base_attr.sv ----
// self-checking bench for the protection region block
`timescale 1ns/1ps
module test_protection_region_base_attr;
  import prot_region_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic        cv = 1'b0, cf = 1'b0, rdy, resp, done, hit, blk;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, ca = 32'h0, hrdata;
  logic [2:0]  hsize = 3'h2, perm;
  logic [3:0]  rgn;
  htrans_type  htrans = 2'h0;
  int          errors = 0, checked = 0;

  always #20 clk = ~clk;

  protection_region_base_attr dut_u (
    .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(rdy), .O_HREADYOUT(rdy), .O_HRDATA(hrdata), .O_HRESP(resp),
    .I_CHK_VALID(cv), .I_CHK_ADDR(ca), .I_CHK_FETCH(cf), .O_CHK_DONE(done),
    .O_CHK_HIT(hit), .O_CHK_REGION(rgn), .O_CHK_PERMISSION(perm), .O_CHK_FETCH_BLOCK(blk)
  );

  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // signals move right after a rising edge; ready and read data are taken at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input word_type d,
                      output word_type q);
    hwrite <= w;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input word_type d);
    word_type q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input word_type e);
    word_type q;
    xfer(1'b0, a, 32'h00000000, q);
    cmp($sformatf("reg %h", a), e, q);
    cmp("resp", 32'h0, {31'h0, resp});
  endtask

  // e packs hit, region, permission, fetch block
  task automatic chk(input word_type a, input logic f, input logic [8:0] e);
    cv <= 1'b1;
    ca <= a;
    cf <= f;
    @(posedge clk);
    cv <= 1'b0;
    @(negedge clk);
    cmp("done", 32'h1, {31'h0, done});
    cmp($sformatf("chk %h", a), {23'h0, e}, {23'h0, hit, rgn, perm, blk});
    @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    report_and_stop();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h00, 32'h00000000);
    rd(8'h04, 32'h00000000);
    rd(8'h08, 32'h00000000);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h0000000F);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h173FFF3F);
    hsize <= 3'h0;
    wr(8'h08, 32'h00000000);
    hsize <= 3'h2;
    rd(8'h08, 32'h173FFF3F);
    wr(8'h04, 32'hFFFFFFE0);
    rd(8'h04, 32'h0000000F);
    chk(32'h12345678, 1'b1, 9'h000);
    wr(8'h08, 32'h1300013F);
    chk(32'h10000000, 1'b1, 9'h000);
    chk(32'h20000000, 1'b1, 9'h1F7);
    chk(32'h20000000, 1'b0, 9'h1F6);
    wr(8'h08, 32'h00000000);
    chk(32'h20000000, 1'b1, 9'h000);
    wr(8'h04, 32'h00004015);
    rd(8'h00, 32'h00000005);
    wr(8'h08, 32'h05000009);
    rd(8'h04, 32'h00004005);
    chk(32'h0000401F, 1'b1, 9'h15A);
    chk(32'h00004020, 1'b0, 9'h000);
    chk(32'h00003FFF, 1'b0, 9'h000);
    wr(8'h04, 32'h00004FE9);
    rd(8'h00, 32'h00000005);
    rd(8'h04, 32'h00004FE5);
    wr(8'h08, 32'h05000013);
    rd(8'h04, 32'h00004C05);
    chk(32'h00004C00, 1'b0, 9'h15A);
    chk(32'h00005000, 1'b0, 9'h000);
    wr(8'h08, 32'h00000001);
    rd(8'h08, 32'h00000009);
    chk(32'h00004FE0, 1'b0, 9'h150);
    wr(8'h08, 32'h05000008);
    chk(32'h00004FE0, 1'b0, 9'h000);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C, 32'h00000000);
    report_and_stop();
  end
endmodule

bind protection_region_base_attr prot_region_chk chk_u (.*);
